// ==== core/runaway_watchdog_map.vh ====
// register offsets, field positions, reset values and counts of the runaway watchdog
`ifndef RUNAWAY_WATCHDOG_MAP_VH
`define RUNAWAY_WATCHDOG_MAP_VH

// ****************************************************************
// clear port index and register byte addresses on the bus
// ****************************************************************
`define WD_IDX_CLEAR_PORT     16'hFFFF
`define WD_ADDR_CLEAR_PORT    18'h3FFFC // four times the clear port index
`define WD_ADDR_CONFIG_ONE    18'h00000
`define WD_ADDR_RESET_CAUSE   18'h00004
`define WD_ADDR_STATUS        18'h00008

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define WD_CFG_DISABLE_BIT    0
`define WD_CFG_RATE_BIT       1
`define WD_CFG_STOP_EN_BIT    2
`define WD_CFG_RESET          8'h00
`define WD_CAUSE_WATCHDOG_BIT 0
`define WD_CAUSE_ILLEGAL_BIT  1
`define WD_CAUSE_RESET        8'h00

// ****************************************************************
// timing
// ****************************************************************
`define WD_PRESCALE_BITS      12
`define WD_COUNTER_BITS       6
`define WD_RESET_PULSE_CYCLES 32
`define WD_POR_CYCLES         4096
`define WD_SHORT_TAP          7
`define WD_LONG_TAP           12

`endif

// ==== core/watchdog_timebase.v ====
// prescaler chain and six-bit watchdog counter
`timescale 1ns/1ps
`include "runaway_watchdog_map.vh"
module watchdog_timebase #(
    parameter PRE_BITS = `WD_PRESCALE_BITS,
    parameter CNT_BITS = `WD_COUNTER_BITS
) (
    input  wire                aclk,
    input  wire                aresetn,
    input  wire                osc_tick,
    input  wire                clr_all,
    input  wire                clr_pre_full,
    input  wire                clr_service,
    input  wire                hold_counter,
    input  wire                rate_sel,
    output reg                 overflow,
    output wire [PRE_BITS-1:0] prescale_value,
    output wire [CNT_BITS-1:0] counter_value
);

    reg  [PRE_BITS-1:0] pre_ff;
    reg  [CNT_BITS-1:0] cnt_ff;
    wire [PRE_BITS-1:0] nxt_pre;
    wire                tap_old;
    wire                tap_new;
    wire                cnt_tick;

    // stage taps choose the timeout length
    assign nxt_pre  = pre_ff + {{(PRE_BITS-1){1'b0}}, 1'b1};
    assign tap_old  = rate_sel ? pre_ff[`WD_SHORT_TAP-1] : pre_ff[`WD_LONG_TAP-1];
    assign tap_new  = rate_sel ? nxt_pre[`WD_SHORT_TAP-1] : nxt_pre[`WD_LONG_TAP-1];
    assign cnt_tick = osc_tick & tap_old & ~tap_new;
    assign prescale_value = pre_ff;
    assign counter_value  = cnt_ff;

    // prescaler with clears of all or upper stages
    always @(posedge aclk)
    begin
        if (!aresetn || clr_all || clr_pre_full)
            pre_ff <= {PRE_BITS{1'b0}};
        else if (clr_service)
            pre_ff <= {{(PRE_BITS-4){1'b0}}, pre_ff[3:0]};
        else if (osc_tick)
            pre_ff <= nxt_pre;
    end

    // watchdog counter and overflow pulse
    always @(posedge aclk)
    begin
        overflow <= 1'b0;
        if (!aresetn || clr_all || clr_service || hold_counter)
            cnt_ff <= {CNT_BITS{1'b0}};
        else if (cnt_tick)
        begin
            cnt_ff <= cnt_ff + {{(CNT_BITS-1){1'b0}}, 1'b1};
            if (&cnt_ff)
                overflow <= 1'b1;
        end
    end

endmodule // watchdog_timebase

// ==== core/runaway_watchdog.v ====
// runaway code watchdog with AXI4-Lite register access
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "runaway_watchdog_map.vh"
module runaway_watchdog #(
    parameter OSC_DIV     = 2500,
    parameter VECTOR_LOW  = 8'h00,
    parameter POR_CYCLES  = `WD_POR_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [17:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [17:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        internal_reset,
    input  wire        vector_fetch,
    input  wire        stop_request,
    input  wire        monitor_mode,
    input  wire        break_active,
    input  wire        test_voltage_irq_pin,
    input  wire        test_voltage_rst_pin,
    output reg         reset_pin_n,
    output reg         watchdog_reset,
    output reg         illegal_opcode_reset,
    output reg         stop_mode
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function [7:0] sel_byte;
        input [31:0] d;
        input [3:0]  s;
        begin
            sel_byte = s[0] ? d[7:0] : 8'h00;
        end
    endfunction

    reg  [2:0]  tvi_sync_ff;
    reg  [2:0]  tvr_sync_ff;
    reg         tvi_ff;
    reg         tvr_ff;
    reg  [7:0]  cfg_ff;
    reg  [7:0]  cause_ff;
    reg         disable_ff;
    reg         rate_ff;
    reg  [15:0] div_ff;
    reg         tick_ff;
    reg  [12:0] por_cnt_ff;
    reg         por_done_ff;
    reg         por_clr_ff;
    reg  [5:0]  pulse_cnt_ff;
    reg  [17:0] awaddr_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;
    reg         aw_have_ff;
    reg         w_have_ff;
    reg         service_ff;
    wire        overflow;
    wire [11:0] pre_value;
    wire [5:0]  cnt_value;
    wire        wd_off;
    wire        do_write;
    wire        tvi_now;
    wire        tvr_now;

    // ****************************************************************
    // oscillator tick and pin synchronisers
    // ****************************************************************
    // oscillator tick from divider, gated in stop mode
    always @(posedge aclk)
    begin
        if (!aresetn || div_ff == OSC_DIV - 1)
            div_ff <= 16'h0000;
        else
            div_ff <= div_ff + 16'h0001;
        tick_ff <= aresetn && div_ff == OSC_DIV - 1 && !stop_mode;
    end

    // three flops; a change counts once the last two agree
    assign tvi_now = tvi_sync_ff[2];
    assign tvr_now = tvr_sync_ff[2];
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tvi_sync_ff <= 3'b000;
            tvr_sync_ff <= 3'b000;
            tvi_ff      <= 1'b0;
            tvr_ff      <= 1'b0;
        end
        else
        begin
            tvi_sync_ff <= {tvi_sync_ff[1:0], test_voltage_irq_pin};
            tvr_sync_ff <= {tvr_sync_ff[1:0], test_voltage_rst_pin};
            if (tvi_sync_ff[1] == tvi_now)
                tvi_ff <= tvi_now;
            if (tvr_sync_ff[1] == tvr_now)
                tvr_ff <= tvr_now;
        end
    end

    // ****************************************************************
    // enable logic
    // ****************************************************************
    // disable and rate config bits sampled on each oscillator tick
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            disable_ff <= 1'b0;
            rate_ff    <= 1'b0;
        end
        else if (tick_ff)
        begin
            disable_ff <= cfg_ff[`WD_CFG_DISABLE_BIT];
            rate_ff    <= cfg_ff[`WD_CFG_RATE_BIT];
        end
    end

    // disable, monitor and break conditions; wait mode has no effect
    assign wd_off = disable_ff
        | (monitor_mode & (tvi_ff | tvr_ff))
        | (break_active & tvr_ff);

    // ****************************************************************
    // power-up prescaler clear
    // ****************************************************************
    always @(posedge aclk)
    begin
        por_clr_ff <= 1'b0;
        if (!aresetn)
        begin
            por_cnt_ff  <= 13'h0000;
            por_done_ff <= 1'b0;
        end
        else if (tick_ff && !por_done_ff)
        begin
            if (por_cnt_ff == POR_CYCLES - 1)
            begin
                por_done_ff <= 1'b1;
                por_clr_ff  <= 1'b1;
            end
            else
                por_cnt_ff <= por_cnt_ff + 13'h0001;
        end
    end

    watchdog_timebase #(
        .PRE_BITS (`WD_PRESCALE_BITS),
        .CNT_BITS (`WD_COUNTER_BITS)
    ) u_timebase (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .osc_tick       (tick_ff),
        .clr_all        (internal_reset),
        .clr_pre_full   (por_clr_ff | vector_fetch | stop_mode),
        .clr_service    (service_ff),
        .hold_counter   (wd_off),
        .rate_sel       (rate_ff),
        .overflow       (overflow),
        .prescale_value (pre_value),
        .counter_value  (cnt_value)
    );

    // ****************************************************************
    // reset generation; no interrupt output exists
    // ****************************************************************
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pulse_cnt_ff         <= 6'h00;
            reset_pin_n          <= 1'b1;
            watchdog_reset       <= 1'b0;
            illegal_opcode_reset <= 1'b0;
            stop_mode            <= 1'b0;
        end
        else
        begin
            watchdog_reset       <= overflow & ~wd_off;
            illegal_opcode_reset <= stop_request & ~cfg_ff[`WD_CFG_STOP_EN_BIT];
            if (internal_reset)
                stop_mode <= 1'b0;
            else if (stop_request && cfg_ff[`WD_CFG_STOP_EN_BIT])
                stop_mode <= 1'b1;
            if (overflow && !wd_off)
            begin
                pulse_cnt_ff <= 6'h20;
                reset_pin_n  <= 1'b0;
            end
            else if (tick_ff && pulse_cnt_ff != 6'h00)
            begin
                pulse_cnt_ff <= pulse_cnt_ff - 6'h01;
                reset_pin_n  <= pulse_cnt_ff == 6'h01;
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;

    // write channel capture in either order, then response
    always @(posedge aclk)
    begin
        service_ff <= 1'b0;
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_have_ff    <= 1'b0;
            w_have_ff     <= 1'b0;
            awaddr_ff     <= 18'h00000;
            wdata_ff      <= 32'h00000000;
            wstrb_ff      <= 4'h0;
            cfg_ff        <= `WD_CFG_RESET;
            cause_ff      <= `WD_CAUSE_RESET;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_ff     <= s_axi_awaddr;
                aw_have_ff    <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                w_have_ff    <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_have_ff   <= 1'b0;
                w_have_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (awaddr_ff & 18'h3FFFC)
                `WD_ADDR_CLEAR_PORT:
                    service_ff <= 1'b1;
                `WD_ADDR_CONFIG_ONE:
                    if (wstrb_ff[0])
                        cfg_ff <= sel_byte(wdata_ff, wstrb_ff);
                `WD_ADDR_RESET_CAUSE:
                    ;
                default:
                    s_axi_bresp <= 2'b10;
                endcase
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            // cause bits: hardware set wins over software clear
            if (do_write && (awaddr_ff & 18'h3FFFC) == `WD_ADDR_RESET_CAUSE && wstrb_ff[0])
                cause_ff <= (cause_ff & ~wdata_ff[7:0])
                    | {6'h00, illegal_opcode_reset, watchdog_reset};
            else
                cause_ff <= cause_ff | {6'h00, illegal_opcode_reset, watchdog_reset};
            if (internal_reset)
                cfg_ff[`WD_CFG_RATE_BIT] <= 1'b0;
        end
    end

    // read channel, one cycle answer
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= 2'b00;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'b00;
            case (s_axi_araddr & 18'h3FFFC)
            `WD_ADDR_CLEAR_PORT:
                s_axi_rdata <= {24'h000000, VECTOR_LOW};
            `WD_ADDR_CONFIG_ONE:
                s_axi_rdata <= {24'h000000, cfg_ff};
            `WD_ADDR_RESET_CAUSE:
                s_axi_rdata <= {24'h000000, cause_ff};
            `WD_ADDR_STATUS:
                s_axi_rdata <= {11'h000, wd_off, pre_value[11:6], cnt_value, pre_value[5:0],
                                reset_pin_n, stop_mode};
            default:
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= 2'b10;
            end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // runaway_watchdog

// ==== tb/runaway_watchdog_assertions.sv ====
// port-level assertions for the runaway watchdog
`timescale 1ns/1ps
module runaway_watchdog_checker #(
    parameter OSC_DIV = 4
) (
    input logic        aclk,
    input logic        aresetn,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic        internal_reset,
    input logic        stop_request,
    input logic        reset_pin_n,
    input logic        watchdog_reset,
    input logic        illegal_opcode_reset,
    input logic        stop_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************************************
    // helper: cycles the reset pin has been held low
    // ****************************************************************
    logic [31:0] low_cnt_ff;
    always @(posedge aclk)
        low_cnt_ff <= (!aresetn || reset_pin_n) ? 32'h00000000 : low_cnt_ff + 32'h00000001;
    // ****************************************************************
    // assertions
    // ****************************************************************
    a_pulse_single: assert property (watchdog_reset |=> !watchdog_reset)
        else $error("watchdog reset pulse longer than one cycle");
    a_pin_follows: assert property ($rose(watchdog_reset) |-> ##[0:8] !reset_pin_n)
        else $error("reset pin not pulled low after overflow");
    a_pin_width: assert property ($rose(reset_pin_n) |->
        low_cnt_ff >= 31 * OSC_DIV && low_cnt_ff <= 33 * OSC_DIV)
        else $error("reset pin low time wrong");
    a_illegal_cause: assert property (illegal_opcode_reset |-> $past(stop_request))
        else $error("illegal opcode reset without stop request");
    a_stop_entry: assert property ($rose(stop_mode) |->
        $past(stop_request) && !illegal_opcode_reset)
        else $error("stop mode entered wrongly");
    a_stop_cleared: assert property (internal_reset |=> !stop_mode)
        else $error("stop mode survives internal reset");
    a_no_wd_after: assert property (internal_reset |=> !watchdog_reset)
        else $error("overflow right after internal reset");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    c_overflow: cover property (watchdog_reset);
    c_illegal: cover property (illegal_opcode_reset);
    c_stop: cover property ($rose(stop_mode));
endmodule // runaway_watchdog_checker

bind runaway_watchdog runaway_watchdog_checker #(.OSC_DIV(OSC_DIV)) i_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .internal_reset(internal_reset),
    .stop_request(stop_request), .reset_pin_n(reset_pin_n),
    .watchdog_reset(watchdog_reset), .illegal_opcode_reset(illegal_opcode_reset),
    .stop_mode(stop_mode));

// ==== tb/testbench.sv ====
// self-checking testbench for the runaway watchdog
`timescale 1ns/1ps
`include "runaway_watchdog_map.vh"
module testbench;
    localparam int DIV = 4;
    localparam logic [7:0] VEC = 8'hA5; // arbitrary vector byte
    localparam logic [17:0] CLR = {`WD_IDX_CLEAR_PORT, 2'b00}; // clear port index times four
    localparam int TMO = 2**13 - 2**4;
    typedef struct packed {logic wr; logic [17:0] a; logic [31:0] d, m, e; logic [1:0] r;} row_t;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, internal_reset, vector_fetch, stop_request, monitor_mode;
    logic        break_active, tv_irq, tv_rst, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, reset_pin_n, watchdog_reset, illegal_opcode_reset;
    logic        stop_mode;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          miscompares, n_tests, i, n;
    // ordinary register cases
    row_t rows [0:9] = '{
        '{0, `WD_ADDR_CONFIG_ONE, 0, 32'hFF, 0, 2'b00},
        '{0, `WD_ADDR_RESET_CAUSE, 0, 32'hFF, 0, 2'b00},
        '{0, CLR, 0, 32'hFF, {24'h0, VEC}, 2'b00},
        '{1, `WD_ADDR_CONFIG_ONE, 32'h7, 0, 0, 2'b00},
        '{0, `WD_ADDR_CONFIG_ONE, 0, 32'h7, 32'h7, 2'b00},
        '{1, `WD_ADDR_CONFIG_ONE, 32'h0, 0, 0, 2'b00},
        '{0, 16'h0010, 0, 32'hFFFFFFFF, 0, 2'b10},
        '{1, `WD_ADDR_STATUS, 32'h1, 0, 0, 2'b10},
        '{1, 16'h0020, 32'h1, 0, 0, 2'b10},
        '{1, CLR, 32'hFFFFFFFF, 0, 0, 2'b00}};
    runaway_watchdog #(.OSC_DIV(DIV), .VECTOR_LOW(VEC), .POR_CYCLES(8)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .internal_reset(internal_reset),
        .vector_fetch(vector_fetch), .stop_request(stop_request),
        .monitor_mode(monitor_mode), .break_active(break_active),
        .test_voltage_irq_pin(tv_irq), .test_voltage_rst_pin(tv_rst),
        .reset_pin_n(reset_pin_n), .watchdog_reset(watchdog_reset),
        .illegal_opcode_reset(illegal_opcode_reset), .stop_mode(stop_mode));
    // ****************************************************************
    // tasks
    // ****************************************************************
    task print_verdict;
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stuck;
        miscompares++;
        print_verdict();
    endtask
    // one write, address and data offered together
    task axi_write(input logic [17:0] a, input logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 100; k++)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (k == 100) stuck();
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // one read
    task axi_read(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 100; k++)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (k == 100) stuck();
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // one-cycle pulse on the stop or internal reset strobe
    task pulse(input logic st, input logic ir);
        @(posedge aclk);
        stop_request <= st;
        internal_reset <= ir;
        @(posedge aclk);
        stop_request <= 1'b0;
        internal_reset <= 1'b0;
        #1;
    endtask
    initial
    begin
        aclk = 0;
        forever #4 aclk = ~aclk;
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
        {internal_reset, vector_fetch, stop_request, monitor_mode, break_active} = 0;
        {tv_irq, tv_rst, miscompares, n_tests} = 0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        check("pin", reset_pin_n, 1);
        check("stop", stop_mode, 0);
        for (i = 0; i < 10; i++)
        begin
            if (rows[i].wr) axi_write(rows[i].a, rows[i].d, rs);
            else axi_read(rows[i].a, rd, rs);
            check("resp", rs, rows[i].r);
            if (!rows[i].wr) check("rdata", rd & rows[i].m, rows[i].e);
        end
        // forbidden stop, then allowed stop, then internal reset
        pulse(1'b1, 1'b0);
        check("illegal", illegal_opcode_reset, 1);
        check("nostop", stop_mode, 0);
        axi_read(`WD_ADDR_RESET_CAUSE, rd, rs);
        check("cause_ill", rd[1], 1);
        axi_write(`WD_ADDR_RESET_CAUSE, 32'h3, rs);
        axi_read(`WD_ADDR_RESET_CAUSE, rd, rs);
        check("cause_clr", rd[1:0], 0);
        axi_write(`WD_ADDR_CONFIG_ONE, 32'h6, rs);
        pulse(1'b1, 1'b0);
        check("stop_in", stop_mode, 1);
        repeat (400) @(posedge aclk);
        axi_read(`WD_ADDR_STATUS, rd, rs);
        check("stop_pre", rd[19:14], 0);
        pulse(1'b0, 1'b1);
        check("stop_out", stop_mode, 0);
        axi_read(`WD_ADDR_CONFIG_ONE, rd, rs);
        check("rate_clr", rd[1], 0);
        // disabled by bit, by monitor voltage, by break voltage
        axi_write(`WD_ADDR_CONFIG_ONE, 32'h3, rs);
        repeat (200) @(posedge aclk);
        axi_read(`WD_ADDR_STATUS, rd, rs);
        check("dis_cnt", {rd[20], rd[13:8]}, 7'h40);
        axi_write(`WD_ADDR_CONFIG_ONE, 32'h2, rs);
        monitor_mode <= 1'b1;
        tv_irq <= 1'b1;
        repeat (20) @(posedge aclk);
        axi_read(`WD_ADDR_STATUS, rd, rs);
        check("mon", rd[20], 1);
        {monitor_mode, tv_irq, break_active, tv_rst} <= 4'h3;
        repeat (20) @(posedge aclk);
        axi_read(`WD_ADDR_STATUS, rd, rs);
        check("brk", rd[20], 1);
        // vector fetch holds the prescaler clear
        {break_active, tv_rst, vector_fetch} <= 3'h1;
        repeat (400) @(posedge aclk);
        axi_read(`WD_ADDR_STATUS, rd, rs);
        check("vec", {rd[20], rd[19:14]}, 0);
        vector_fetch <= 1'b0;
        // let the counter advance so the service has something to clear
        repeat (1100) @(posedge aclk);
        axi_read(`WD_ADDR_STATUS, rd, rs);
        check("pre_svc", rd[13:8] != 0, 1);
        // service, then let the short timeout run out
        axi_write(CLR, 32'h0, rs);
        axi_read(`WD_ADDR_STATUS, rd, rs);
        check("svc", {rd[19:14], rd[13:8]}, 0);
        for (n = 0; n < 40000 && watchdog_reset !== 1'b1; n++) @(posedge aclk);
        check("tmo", n >= (TMO - 16) * DIV && n <= (TMO + 16) * DIV + 8, 1);
        repeat (10) @(posedge aclk);
        check("pin_lo", reset_pin_n, 0);
        repeat (200) @(posedge aclk);
        check("pin_hi", reset_pin_n, 1);
        axi_read(`WD_ADDR_RESET_CAUSE, rd, rs);
        check("cause_wd", rd[0], 1);
        print_verdict();
    end
endmodule // testbench
